// ---- bench/tb_rt_tx_mode_code_descriptor_control.sv ----
`timescale 1ns/100ps
module tb_rt_tx_mode_code_descriptor_control;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic user_write = 1'b0, user_read = 1'b0, user_execute = 1'b0, user_soft_reset = 1'b0;
  logic [15:0] user_wdata = 16'h0000;
  logic [15:0] user_rdata, w, d, e;
  logic user_rdata_valid, buffer_service_ok, broadcast_invalid_flag = 1'b0, irq_global = 1'b1;
  logic cmd_start = 1'b0, cmd_transmit = 1'b0, cmd_done = 1'b0, cmd_error = 1'b0;
  logic [4:0] cmd_subaddr = 5'h00, cmd_rt_address = 5'h00, cmd_mode_code = 5'h00;
  logic [7:0] message_index_count = 8'h00;
  logic busy_reply, send_data_word, use_pointer_b, pingpong_in_use;
  logic message_irq_output, index_zero_event, accessed_event, broadcast_event;
  logic [15:0] exp_q[$];
  int n_errors = 0, samples_checked = 0, seed = 32'h7aa4_fa19;
  txmcw_if txmcw_if_i (.clock, .reset_n);
  txmcw_device txmcw_device_i (.bus(txmcw_if_i), .broadcast_invalid_flag,
    .index_zero_irq_global(irq_global), .accessed_irq_global(irq_global),
    .broadcast_irq_global(irq_global), .cmd_start, .cmd_transmit, .cmd_subaddr,
    .cmd_rt_address, .cmd_mode_code, .cmd_done, .cmd_error, .message_index_count, .busy_reply,
    .send_data_word, .use_pointer_b, .pingpong_in_use, .message_irq_output, .index_zero_event,
    .accessed_event, .broadcast_event);
  txmcw_host txmcw_host_i (.bus(txmcw_if_i), .user_write, .user_read, .user_wdata,
    .user_execute, .user_soft_reset, .user_rdata, .user_rdata_valid, .buffer_service_ok);
  txmcw_asserts txmcw_asserts_i (.clock, .reset_n, .host_write(txmcw_if_i.host_write),
    .host_read(txmcw_if_i.host_read), .host_wdata(txmcw_if_i.host_wdata),
    .host_rdata(txmcw_if_i.host_rdata), .software_reset_cmd(txmcw_if_i.software_reset_cmd),
    .terminal_execute_flag(txmcw_if_i.terminal_execute_flag));
  // ----------------
  // Helpers
  // ----------------
  initial
  begin
    forever #20 clock = ~clock;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic results();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic op(input logic [2:0] k, input logic [15:0] dat, input logic [15:0] e);
    @(negedge clock);
    {user_read, user_write, user_soft_reset} = k;
    user_wdata = dat;
    if (k[2])
      exp_q.push_back(e);
  endtask
  task automatic idle(input int n);
    repeat (n) op(3'b000, 16'h0000, 16'h0000);
  endtask
  task automatic cmd(input logic t, input logic [4:0] sa, rt, mc, input logic er,
    input logic [7:0] ix, input logic [2:0] rsp, input logic [4:0] ev);
    logic [3:0] seen;
    @(negedge clock);
    {user_read, user_write, user_soft_reset} = 3'b000;
    {cmd_start, cmd_transmit, cmd_subaddr, cmd_rt_address, cmd_mode_code} = {1'b1, t, sa, rt, mc};
    @(negedge clock);
    cmd_start = 1'b0;
    check({13'h0000, pingpong_in_use, busy_reply, send_data_word}, {13'h0000, rsp});
    @(negedge clock);
    {cmd_done, cmd_error, message_index_count} = {1'b1, er, ix};
    seen = 4'h0;
    repeat (4)
    begin
      @(negedge clock);
      cmd_done = 1'b0;
      seen = seen | {message_irq_output, index_zero_event, accessed_event, broadcast_event};
    end
    check({11'h000, use_pointer_b, seen}, {11'h000, ev});
  endtask
  always @(negedge clock)
  begin
    if (user_rdata_valid === 1'b1)
    begin
      check(16'(exp_q.size() != 0), 16'h0001);
      e = (exp_q.size() != 0) ? exp_q.pop_front() : ~user_rdata;
      check(user_rdata, e);
      check(16'(buffer_service_ok), 16'(!e[8]));
    end
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    n_errors++;
    $display("unexpected at %0t: run too long", $time);
    results();
  end
  initial
  begin
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    op(3'b100, 16'h0000, 16'h0000);
    w = 16'h0000;
    repeat (4)
    begin
      d = 16'($random(seed));
      op(3'b100, 16'h0000, w);
      op(3'b010, d, 16'h0000);
      w = d & 16'hf00c;
      op(3'b100, 16'h0000, w);
    end
    op(3'b100, 16'h0000, w);
    op(3'b010, 16'h6004, 16'h0000);
    idle(1);
    user_execute = 1'b1;
    idle(4);
    $display("test host writes done");
    op(3'b100, 16'h0000, 16'h6104);
    op(3'b010, 16'h6000, 16'h0000);
    op(3'b100, 16'h0000, 16'h6104);
    op(3'b010, 16'h600c, 16'h0000);
    idle(3);
    op(3'b100, 16'h0000, 16'h600c);
    op(3'b010, 16'h6004, 16'h0000);
    idle(3);
    op(3'b100, 16'h0000, 16'h6104);
    $display("test handshake done");
    cmd(1'b1, 5'h00, 5'h05, 5'h10, 1'b0, 8'h01, 3'b101, 5'b11010);
    op(3'b100, 16'h0000, 16'h6d04);
    op(3'b100, 16'h0000, 16'h6504);
    cmd(1'b1, 5'h1f, 5'h05, 5'h04, 1'b1, 8'h01, 3'b100, 5'b10000);
    op(3'b100, 16'h0000, 16'h6d04);
    cmd(1'b1, 5'h1f, 5'h1f, 5'h14, 1'b0, 8'h01, 3'b101, 5'b01011);
    op(3'b100, 16'h0000, 16'h6b04);
    broadcast_invalid_flag = 1'b1;
    cmd(1'b1, 5'h00, 5'h1f, 5'h14, 1'b0, 8'h01, 3'b000, 5'b00000);
    broadcast_invalid_flag = 1'b0;
    cmd(1'b0, 5'h00, 5'h05, 5'h14, 1'b0, 8'h01, 3'b000, 5'b00000);
    cmd(1'b1, 5'h05, 5'h05, 5'h14, 1'b0, 8'h01, 3'b000, 5'b00000);
    op(3'b100, 16'h0000, 16'h6304);
    op(3'b010, 16'h7004, 16'h0000);
    idle(2);
    cmd(1'b1, 5'h00, 5'h05, 5'h11, 1'b0, 8'h01, 3'b110, 5'b01010);
    cmd(1'b1, 5'h00, 5'h05, 5'h08, 1'b0, 8'h01, 3'b100, 5'b11010);
    op(3'b100, 16'h0000, 16'h7f04);
    op(3'b001, 16'h0000, 16'h0000);
    op(3'b100, 16'h0000, 16'h7104);
    $display("test commands done");
    user_execute = 1'b0;
    idle(2);
    op(3'b010, 16'h8000, 16'h0000);
    idle(1);
    user_execute = 1'b1;
    idle(3);
    cmd(1'b1, 5'h00, 5'h05, 5'h02, 1'b0, 8'h00, 3'b000, 5'b01100);
    cmd(1'b1, 5'h00, 5'h05, 5'h02, 1'b0, 8'h01, 3'b000, 5'b00000);
    user_execute = 1'b0;
    idle(2);
    op(3'b100, 16'h0000, 16'h8800);
    op(3'b100, 16'h0000, 16'h8000);
    idle(6);
    $display("test indexed done");
    check(16'(exp_q.size()), 16'h0000);
    results();
  end
endmodule

// ---- bench/txmcw_asserts.sv ----
`timescale 1ns/100ps
module txmcw_asserts
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Host access
  input wire logic host_write,
  input wire logic host_read,
  input wire logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata,
  // Configuration
  input wire logic terminal_execute_flag,
  input wire logic software_reset_cmd
);
  // ----------------
  // Word checks
  // ----------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  a_reset_word_zero: assert property ($rose(reset_n) |-> host_rdata == 16'h0000)
    else $error("word not clear after reset");
  a_write_readback: assert property (host_write && !terminal_execute_flag ##1 host_read &&
    !host_write && !software_reset_cmd |=> (host_rdata & 16'hf00c) == ($past(host_wdata, 2) &
    16'hf00c)) else $error("host bits not written");
  a_bit2_locked: assert property (host_read ##1 host_write && terminal_execute_flag &&
    !host_read ##1 host_read && !host_write |=> host_rdata[2] == $past(host_rdata[2], 2))
    else $error("bit 2 written while executing");
  a_status_ro: assert property (host_read ##1 host_write && !terminal_execute_flag &&
    !host_read && !software_reset_cmd ##1 host_read && !host_write |=>
    host_rdata[10:8] == $past(host_rdata[10:8], 2)) else $error("status bits written");
  a_read_clears: assert property (host_read && !terminal_execute_flag ##1 host_read &&
    !terminal_execute_flag |=> !host_rdata[11]) else $error("accessed flag kept after read");
  a_soft_reset: assert property (host_read ##1 software_reset_cmd && !host_write &&
    !host_read ##1 host_read && !host_write |=> host_rdata[11:9] == 3'b000 &&
    host_rdata[15:12] == $past(host_rdata[15:12], 2)) else $error("soft reset wrong bits");
  a_ack_tracks: assert property ((terminal_execute_flag && !host_write) [*2] ##0 host_read
    |=> host_rdata[8] == (host_rdata[2] && !host_rdata[3])) else $error("ack bit wrong");
  a_rdata_holds: assert property (!host_read |=> $stable(host_rdata))
    else $error("read data moved without read");
  c_readback: cover property (host_write ##1 host_read);
  c_soft: cover property (software_reset_cmd ##1 host_read);
  c_ack: cover property (terminal_execute_flag && host_rdata[8]);
endmodule

// ---- hw/txmcw_decode.sv ----
`timescale 1ns/100ps
module txmcw_decode
  import txmcw_pkg::*;
(
  // Command fields
  input wire logic cmd_transmit,
  input wire logic [4:0] cmd_subaddr,
  input wire logic [4:0] cmd_rt_address,
  input wire logic [4:0] cmd_mode_code,
  input wire logic broadcast_invalid_flag,
  // Decode results
  output logic uses_word,
  output logic is_broadcast,
  output logic is_valid,
  output logic is_reset_terminal,
  output logic has_data_word
);
  always_comb
  begin
    uses_word = cmd_transmit &&
      (cmd_subaddr == SUBADDR_MODE_LOW || cmd_subaddr == SUBADDR_MODE_HIGH);
    is_broadcast = cmd_rt_address == BROADCAST_ADDRESS;
    is_valid = !(is_broadcast && broadcast_invalid_flag);
    is_reset_terminal = cmd_mode_code == MODE_RESET_TERMINAL;
    has_data_word = cmd_mode_code >= MODE_DATA_FIRST;
  end
endmodule

// ---- hw/txmcw_device.sv ----
`timescale 1ns/100ps
// Function
// - Word serves transmit mode commands, subaddress 0/31
// - Bits 8-11 device-owned, updated while executing
// - Host writes bit 2 only when idle
// - Master reset clears whole word
// - Software reset clears bits 9, 10, 11
// - Host read clears block accessed flag
// - Index one-to-zero raises enabled message interrupt
// - Valid error-free command using the word raises enabled accessed interrupt
// - Valid error-free broadcast raises enabled broadcast interrupt
// - Broadcast invalid flag disables broadcast handling
// - Force busy: busy reply, no data, no toggle
// - Reset terminal mode code ignores force busy
// - Completion sets block accessed flag
// - Buffer select picks pointer A or B
// - Toggle select only after error-free messages
// - First message after reset uses buffer A
// - Indexed mode pointer still follows buffer select
// - Valid broadcast transmit sets broadcast received
// - Ping-pong ack set while ping-pong active
// - Pause request handshake via ping-pong ack
// - Host services buffer only while ack low
// - Unacknowledged ping-pong uses select, no toggle
// - Host sets bit 2 for ping-pong
module txmcw_device
  import txmcw_pkg::*;
#(
  parameter int unsigned INDEX_WIDTH = 8
)
(
  // Host side
  txmcw_if.device bus,
  // Global settings
  input wire logic broadcast_invalid_flag,
  input wire logic index_zero_irq_global,
  input wire logic accessed_irq_global,
  input wire logic broadcast_irq_global,
  // Command from protocol engine
  input wire logic cmd_start,
  input wire logic cmd_transmit,
  input wire logic [4:0] cmd_subaddr,
  input wire logic [4:0] cmd_rt_address,
  input wire logic [4:0] cmd_mode_code,
  input wire logic cmd_done,
  input wire logic cmd_error,
  input wire logic [INDEX_WIDTH-1:0] message_index_count,
  // Command response
  output logic busy_reply,
  output logic send_data_word,
  output logic use_pointer_b,
  output logic pingpong_in_use,
  // Interrupt events
  output logic message_irq_output,
  output logic index_zero_event,
  output logic accessed_event,
  output logic broadcast_event
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] word;
    logic active;
    logic broadcast;
    logic busy;
    logic pingpong;
    logic [15:0] rdata;
    logic irq;
    logic ev_index;
    logic ev_access;
    logic ev_broadcast_received_flag;
  } txmcw_state_t;

  txmcw_state_t state_ff;
  txmcw_state_t nxt_state;

  logic uses_word;
  logic is_broadcast;
  logic is_valid;
  logic is_reset_terminal;
  logic has_data_word;

  txmcw_decode txmcw_decode_i (
    .cmd_transmit(cmd_transmit),
    .cmd_subaddr(cmd_subaddr),
    .cmd_rt_address(cmd_rt_address),
    .cmd_mode_code(cmd_mode_code),
    .broadcast_invalid_flag(broadcast_invalid_flag),
    .uses_word(uses_word),
    .is_broadcast(is_broadcast),
    .is_valid(is_valid),
    .is_reset_terminal(is_reset_terminal),
    .has_data_word(has_data_word)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [15:0] host_mask;
    logic run;
    logic busy_now;
    logic ok_done;
    host_mask = 16'h0000;
    run = 1'b0;
    busy_now = 1'b0;
    ok_done = 1'b0;
    nxt_state = state_ff;
    nxt_state.ev_index = 1'b0;
    nxt_state.ev_access = 1'b0;
    nxt_state.ev_broadcast_received_flag = 1'b0;
    run = bus.terminal_execute_flag;
    // Host write, host bits only
    host_mask = HOST_ANYTIME_MASK;
    if (!run)
    begin
      host_mask = host_mask | HOST_IDLE_MASK;
    end
    if (bus.host_write)
    begin
      nxt_state.word = (state_ff.word & ~host_mask) | (bus.host_wdata & host_mask);
    end
    // Ping-pong handshake
    if (run)
    begin
      nxt_state.word[BIT_PINGPONG_ACK] = state_ff.word[BIT_PINGPONG_ENABLE] &&
        !state_ff.word[BIT_PAUSE_REQUEST];
    end
    // Command start latches response mode
    if (cmd_start && uses_word && is_valid && run)
    begin
      busy_now = state_ff.word[BIT_FORCE_BUSY] && !is_reset_terminal;
      nxt_state.active = 1'b1;
      nxt_state.broadcast = is_broadcast;
      nxt_state.busy = busy_now;
      nxt_state.pingpong = state_ff.word[BIT_PINGPONG_ENABLE] &&
        state_ff.word[BIT_PINGPONG_ACK];
    end
    // Completion updates status bits and interrupt events
    if (state_ff.active && cmd_done)
    begin
      nxt_state.active = 1'b0;
      ok_done = !cmd_error;
      nxt_state.word[BIT_BLOCK_ACCESSED] = 1'b1;
      if (state_ff.broadcast)
      begin
        nxt_state.word[BIT_BROADCAST_RECEIVED] = 1'b1;
      end
      if (state_ff.pingpong && ok_done && !state_ff.busy)
      begin
        nxt_state.word[BIT_BUFFER_SELECT] = !state_ff.word[BIT_BUFFER_SELECT];
      end
      if (ok_done)
      begin
        nxt_state.ev_index = state_ff.word[BIT_INDEX_ZERO_IRQ] && index_zero_irq_global &&
          !state_ff.pingpong && message_index_count == '0;
        nxt_state.ev_access = state_ff.word[BIT_ACCESSED_IRQ] && accessed_irq_global;
        nxt_state.ev_broadcast_received_flag = state_ff.word[BIT_BROADCAST_IRQ] && broadcast_irq_global &&
          state_ff.broadcast;
      end
    end
    // Host read clears accessed flag; completion set wins
    if (bus.host_read && !(state_ff.active && cmd_done))
    begin
      nxt_state.word[BIT_BLOCK_ACCESSED] = 1'b0;
    end
    if (bus.host_read)
    begin
      nxt_state.rdata = state_ff.word;
    end
    // Software reset
    if (bus.software_reset_cmd)
    begin
      nxt_state.word = state_ff.word & ~SOFT_RESET_CLEAR_MASK;
      nxt_state.active = 1'b0;
    end
    nxt_state.irq = nxt_state.ev_index || nxt_state.ev_access || nxt_state.ev_broadcast_received_flag;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge bus.clock or negedge bus.reset_n)
  begin
    if (!bus.reset_n)
    begin
      state_ff <= '0;
      state_ff.word <= CONTROL_WORD_RESET;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus.host_rdata = state_ff.rdata;
  assign busy_reply = state_ff.active && state_ff.busy;
  assign send_data_word = state_ff.active && !state_ff.busy && has_data_word;
  assign use_pointer_b = state_ff.word[BIT_BUFFER_SELECT];
  assign pingpong_in_use = state_ff.active && state_ff.pingpong;
  assign message_irq_output = state_ff.irq;
  assign index_zero_event = state_ff.ev_index;
  assign accessed_event = state_ff.ev_access;
  assign broadcast_event = state_ff.ev_broadcast_received_flag;
endmodule

// ---- hw/txmcw_host.sv ----
`timescale 1ns/100ps
module txmcw_host
  import txmcw_pkg::*;
(
  // Device side
  txmcw_if.host bus,
  // User requests
  input wire logic user_write,
  input wire logic user_read,
  input wire logic [15:0] user_wdata,
  input wire logic user_execute,
  input wire logic user_soft_reset,
  // User results
  output logic [15:0] user_rdata,
  output logic user_rdata_valid,
  output logic buffer_service_ok
);
  typedef struct packed {
    logic write;
    logic read;
    logic [15:0] wdata;
    logic execute;
    logic soft_reset;
    logic pend;
    logic rvalid;
    logic [15:0] rdata;
  } txmcw_host_state_t;

  txmcw_host_state_t state_ff;
  txmcw_host_state_t nxt_state;

  // ----------------------------------------
  // Request staging
  // ----------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.write = user_write;
    nxt_state.read = user_read && !user_write;
    nxt_state.wdata = user_wdata;
    // Bit 2 kept unchanged while executing
    if (state_ff.execute)
    begin
      nxt_state.wdata[BIT_PINGPONG_ENABLE] = state_ff.wdata[BIT_PINGPONG_ENABLE];
    end
    nxt_state.execute = user_execute;
    nxt_state.soft_reset = user_soft_reset;
    // Read data and valid rise together, one cycle after the device register
    nxt_state.pend = state_ff.read;
    nxt_state.rvalid = state_ff.pend;
    if (state_ff.pend)
    begin
      nxt_state.rdata = bus.host_rdata;
    end
  end

  always_ff @(posedge bus.clock or negedge bus.reset_n)
  begin
    if (!bus.reset_n)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign bus.host_write = state_ff.write;
  assign bus.host_read = state_ff.read;
  assign bus.host_wdata = state_ff.wdata;
  assign bus.terminal_execute_flag = state_ff.execute;
  assign bus.software_reset_cmd = state_ff.soft_reset;
  assign user_rdata = state_ff.rdata;
  assign user_rdata_valid = state_ff.rvalid;
  assign buffer_service_ok = !state_ff.rdata[BIT_PINGPONG_ACK];
endmodule

// ---- hw/txmcw_if.sv ----
`timescale 1ns/100ps
interface txmcw_if
  import txmcw_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n
);
  // Host access to the word
  logic host_write;
  logic host_read;
  logic [15:0] host_wdata;
  logic [15:0] host_rdata;
  // Configuration
  logic terminal_execute_flag;
  logic software_reset_cmd;
  modport device (
    input clock, reset_n, host_write, host_read, host_wdata,
    input terminal_execute_flag, software_reset_cmd,
    output host_rdata
  );
  modport host (
    input clock, reset_n, host_rdata,
    output host_write, host_read, host_wdata,
    output terminal_execute_flag, software_reset_cmd
  );
endinterface

// ---- hw/txmcw_pkg.sv ----
package txmcw_pkg;
  // Control word bit positions
  localparam int unsigned BIT_INDEX_ZERO_IRQ = 15;
  localparam int unsigned BIT_ACCESSED_IRQ = 14;
  localparam int unsigned BIT_BROADCAST_IRQ = 13;
  localparam int unsigned BIT_FORCE_BUSY = 12;
  localparam int unsigned BIT_BLOCK_ACCESSED = 11;
  localparam int unsigned BIT_BUFFER_SELECT = 10;
  localparam int unsigned BIT_BROADCAST_RECEIVED = 9;
  localparam int unsigned BIT_PINGPONG_ACK = 8;
  localparam int unsigned BIT_PAUSE_REQUEST = 3;
  localparam int unsigned BIT_PINGPONG_ENABLE = 2;
  // Reset value and write masks
  localparam logic [15:0] CONTROL_WORD_RESET = 16'h0000;
  localparam logic [15:0] HOST_ANYTIME_MASK = 16'hF008;
  localparam logic [15:0] HOST_IDLE_MASK = 16'h0004;
  localparam logic [15:0] DEVICE_STATUS_MASK = 16'h0F00;
  localparam logic [15:0] SOFT_RESET_CLEAR_MASK = 16'h0E00;
  // Command decode values
  localparam logic [4:0] SUBADDR_MODE_LOW = 5'h00;
  localparam logic [4:0] SUBADDR_MODE_HIGH = 5'h1F;
  localparam logic [4:0] BROADCAST_ADDRESS = 5'h1F;
  localparam logic [4:0] MODE_RESET_TERMINAL = 5'h08;
  localparam logic [4:0] MODE_DATA_FIRST = 5'h10;
endpackage
